// File: bench/am_depth_and_antenna_trim_tb_top.sv
// self-checking bench for the AM depth and antenna trim block
`timescale 1ns/1ns
`default_nettype none
module am_depth_and_antenna_trim_tb_top;
	logic        ref_clk_in   = 1'b0;
	logic        srst_in      = 1'b1;
	logic        hsel_in      = 1'b1;
	logic [31:0] haddr_in     = 32'h0;
	logic [1:0]  htrans_in    = 2'h0;
	logic        hwrite_in    = 1'b0;
	logic [2:0]  hsize_in     = 3'h2;
	logic [31:0] hwdata_in    = 32'h0;
	logic        mod_in       = 1'b0;
	logic [3:0]  auto_trim_in = 4'h0;
	logic [3:0]  lat          = 4'h1;
	logic        rd_flag      = 1'b0;
	logic [31:0] hrdata_out;
	logic        hreadyout_out, hresp_out, tx_en_out, adc_start_out, adc_done_in, cal_done_out;
	logic [7:0]  adc_data_in, drive_out_a, drive_out_b;
	logic [3:0]  tune_sw_a, tune_sw_b;
	wire         hready_in = hreadyout_out;
	logic [31:0] rd_q[$];
	int          err_total = 0, total_checks = 0, cycles = 0, cal_cnt = 0;

	always #5 ref_clk_in = ~ref_clk_in;

	amd_top amd_top_inst (.ref_clk_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
		.hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .mod_in, .tx_en_out, .adc_start_out,
		.adc_done_in, .adc_data_in, .cal_done_out, .drive_out_a, .drive_out_b, .auto_trim_in, .tune_sw_a,
		.tune_sw_b);

	amd_field_model amd_field_model_inst (.ref_clk_in, .srst_in, .adc_start_in(adc_start_out),
		.drive_a_in(drive_out_a), .drive_b_in(drive_out_b), .lat_in(lat), .adc_done_out(adc_done_in),
		.adc_data_out(adc_data_in));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("BAD bus t=%0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("BAD pin t=%0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	// single word transfer; for a read d is the expected data
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		htrans_in <= 2'h2;
		haddr_in  <= {24'h0, a};
		hwrite_in <= w;
		do @(posedge ref_clk_in); while (hready_in !== 1'b1);
		htrans_in <= 2'h0;
		rd_flag   <= !w;
		if (w)
			hwdata_in <= d;
		else
			rd_q.push_back(d);
		do @(posedge ref_clk_in); while (hready_in !== 1'b1);
		rd_flag <= 1'b0;
	endtask

	function automatic logic [7:0] amp_of(input logic [7:0] lvl);
		return 8'hff - {1'b0, lvl[7:1]};
	endfunction

	function automatic logic [7:0] exp_disp(input logic [7:0] ad, input logic [5:0] code);
		logic [7:0] tgt, lvl, tr, s, best;
		logic [8:0] e, be;
		tgt  = 8'({ad, 6'h00} / {8'h00, 1'b1, code});
		lvl  = 8'h00;
		be   = 9'h100;
		best = 8'h00;
		for (int b = 7; b >= 0; b--)
		begin
			tr = lvl | (8'h01 << b);
			s  = amp_of(tr);
			e  = (s >= tgt) ? 9'(s - tgt) : 9'(tgt - s);
			if (e < be)
			begin
				be   = e;
				best = tr;
			end
			if (s >= tgt)
				lvl = tr;
		end
		return best;
	endfunction

	// result watcher and hang limit
	always @(posedge ref_clk_in)
	begin
		cycles <= cycles + 1;
		if (cal_done_out === 1'b1)
			cal_cnt++;
		if (rd_flag && hreadyout_out === 1'b1)
			chk_bus({hrdata_out[31:1], hresp_out | hrdata_out[0]}, rd_q.pop_front());
		if (cycles > 30000)
		begin
			err_total++;
			end_of_test();
		end
	end

	initial
	begin
		logic [7:0] norm, ad, dsp, ml;
		logic [5:0] code;
		logic [3:0] at;
		int         n;
		void'($urandom(32'h2b94254c));
		repeat (6) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(posedge ref_clk_in);
		for (int i = 0; i < 10; i++)
			bus(8'(i * 4), 1'b0, 32'h0);
		chk_pin(drive_out_a & drive_out_b, 8'hff);
		chk_pin({tune_sw_a, tune_sw_b}, 8'h00);
		bus(amd_pkg::A_TRIM_CTRL, 1'b1, 32'h20);
		for (int r = 0; r < 5; r++)
		begin
			code = (r == 0) ? 6'h00 : (r == 1) ? 6'h3f : (r == 2) ? 6'h0e : 6'($urandom);
			norm = (r < 2) ? 8'h00 : 8'($urandom_range(0, 63));
			lat    <= 4'($urandom_range(1, 8));
			mod_in <= 1'b0;
			bus(amd_pkg::A_NORM_LVL, 1'b1, {24'h0, norm});
			bus(amd_pkg::A_DEPTH_CTRL, 1'b1, {25'h0, code, 1'b0});
			chk_pin(drive_out_a, ~norm);
			bus(amd_pkg::A_CMD, 1'b1, 32'h1);
			bus(amd_pkg::A_CMD, 1'b1, 32'h1);
			bus(amd_pkg::A_STATUS, 1'b0, 32'h1);
			chk_pin({7'h0, tx_en_out}, 8'h01);
			ad  = amp_of(norm);
			dsp = exp_disp(ad, code);
			n   = cal_cnt;
			while (cal_cnt == n)
				@(posedge ref_clk_in);
			repeat (4) @(posedge ref_clk_in);
			chk_pin({7'h0, tx_en_out}, 8'h00);
			bus(amd_pkg::A_ADC_OUT, 1'b0, {24'h0, ad});
			bus(amd_pkg::A_DEPTH_DISP, 1'b0, {24'h0, dsp});
			bus(amd_pkg::A_STATUS, 1'b0, 32'h2);
			bus(amd_pkg::A_STATUS, 1'b1, 32'h2);
			bus(amd_pkg::A_STATUS, 1'b0, 32'h0);
			mod_in <= 1'b1;
			repeat (2) @(posedge ref_clk_in);
			chk_pin(drive_out_a, ~dsp);
			chk_pin(drive_out_b, ~dsp);
		end
		ml = 8'($urandom);
		// external calibration: trial levels through the normal register, then restore it
		bus(amd_pkg::A_NORM_LVL, 1'b1, 32'h0);
		bus(amd_pkg::A_NORM_LVL, 1'b1, {24'h0, ml});
		bus(amd_pkg::A_MOD_LVL, 1'b1, {24'h0, ml});
		bus(amd_pkg::A_NORM_LVL, 1'b1, {24'h0, norm});
		bus(amd_pkg::A_DEPTH_CTRL, 1'b1, 32'h80);
		repeat (2) @(posedge ref_clk_in);
		chk_pin(drive_out_a, ~ml);
		bus(amd_pkg::A_MOD_LVL, 1'b0, {24'h0, ml});
		mod_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk_pin(drive_out_b, ~norm);
		for (int c = 0; c < 16; c++)
		begin
			at = 4'($urandom);
			auto_trim_in <= at;
			bus(amd_pkg::A_TRIM_CTRL, 1'b1, 32'h30 | c);
			repeat (2) @(posedge ref_clk_in);
			chk_pin({tune_sw_a, tune_sw_b}, {4'(c), 4'(c)});
			bus(amd_pkg::A_TRIM_CTRL, 1'b1, 32'h10 | c);
			repeat (2) @(posedge ref_clk_in);
			chk_pin({tune_sw_a, tune_sw_b}, {4'(c), 4'h0});
			bus(amd_pkg::A_TRIM_CTRL, 1'b1, 32'h20);
			repeat (2) @(posedge ref_clk_in);
			chk_pin({tune_sw_a, tune_sw_b}, {at, at});
		end
		// reset in the middle of a calibration run
		bus(amd_pkg::A_CMD, 1'b1, 32'h1);
		srst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(posedge ref_clk_in);
		chk_pin({7'h0, tx_en_out}, 8'h00);
		bus(amd_pkg::A_STATUS, 1'b0, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire

// File: bench/amd_field_model.sv
// antenna tank and amplitude converter model facing the driver segments
`timescale 1ns/1ns
`default_nettype none
module amd_field_model
(
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       srst_in,
	// sample request and driver segment state
	input  wire logic       adc_start_in,
	input  wire logic [7:0] drive_a_in,
	input  wire logic [7:0] drive_b_in,
	input  wire logic [3:0] lat_in,
	// sample answer
	output logic            adc_done_out,
	output logic      [7:0] adc_data_out
);
	logic       busy;
	logic [3:0] cnt;
	// both drivers feed the tank, weaker segments lower the field
	wire  [8:0] lvl_sum = {1'b0, ~drive_a_in} + {1'b0, ~drive_b_in};

	always_ff @(posedge ref_clk_in)
	begin
		adc_done_out <= 1'b0;
		// data line is not valid outside a sample
		adc_data_out <= ~adc_data_out;
		if (srst_in)
		begin
			busy         <= 1'b0;
			cnt          <= 4'h0;
			adc_data_out <= 8'h5a;
		end
		else if (adc_start_in)
		begin
			busy <= 1'b1;
			cnt  <= lat_in;
		end
		else if (busy)
		begin
			if (cnt == 4'h0)
			begin
				busy         <= 1'b0;
				adc_done_out <= 1'b1;
				adc_data_out <= 8'hff - {1'b0, lvl_sum[8:2]};
			end
			else
				cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: hw/amd_div.sv
// sequential divider for the target modulated level
`timescale 1ns/1ns
`default_nettype none
module amd_div
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        srst_in,
	// request
	input  wire logic        start_in,
	input  wire logic [13:0] num_in,
	input  wire logic [6:0]  den_in,
	// answer
	output logic      [7:0]  quo_out,
	output logic             done_out
);
	typedef struct packed {
		logic [13:0] q;
		logic [6:0]  rem;
		logic [6:0]  den;
		logic [3:0]  cnt;
		logic        busy;
		logic        done;
	} amd_div_s;

	amd_div_s r;
	amd_div_s next_r;
	logic [7:0] trial;

	always_comb
	begin
		next_r = r;
		trial = {r.rem, r.q[13]};
		next_r.done = 1'b0;
		if (!r.busy && start_in)
		begin
			next_r.q = num_in;
			next_r.rem = 7'h00;
			next_r.den = den_in;
			next_r.cnt = amd_pkg::DIV_STEPS;
			next_r.busy = 1'b1;
		end
		else if (r.busy)
		begin
			// restoring step, one quotient bit per cycle
			if (trial >= {1'b0, r.den})
			begin
				next_r.rem = 7'(trial - {1'b0, r.den});
				next_r.q = {r.q[12:0], 1'b1};
			end
			else
			begin
				next_r.rem = trial[6:0];
				next_r.q = {r.q[12:0], 1'b0};
			end
			next_r.cnt = r.cnt - 4'h1;
			if (r.cnt == 4'h1)
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign quo_out = r.q[7:0];
	assign done_out = r.done;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	div_latency_a: assert property (!r.busy && start_in |-> ##15 done_out) // [RL7]
		else $error("divider result not ready after fifteen cycles");
	div_exact_a: assert property (done_out |-> ({1'b0, r.rem} < {1'b0, r.den}) // [RL1]
		&& ({8'h00, r.q} * {15'h0000, r.den} + {15'h0000, r.rem} == {8'h00, num_in}))
		else $error("divider quotient and remainder do not rebuild the dividend");
endmodule
`default_nettype wire

// File: hw/amd_pkg.sv
// constants and types for the AM depth and antenna trim block
// Functional notes
// RL1: target level is measured unmodulated level divided by binary 1.depth_code.
// RL2: depth codes map monotonically, all-zero gives 0 percent, all-ones 33 percent.
// RL3: modulated level raises resistance of both drivers, eight binary-weighted segments each.
// RL4: unmodulated state enables all segments unless normal-level register disables some.
// RL5: controller starts oscillator and regulators before the calibrate command.
// RL6: calibrate enables transmitter unmodulated, measures carrier by ADC, stores result.
// RL7: after measuring, compute target modulated level from measurement and depth code.
// RL8: successive approximation bit by bit, keep setting whose field is closest.
// RL9: final strength goes to display register, which then sets the modulated level.
// RL10: controller should not change normal level after calibration.
// RL11: controller runs antenna calibration before depth calibration when both used.
// RL12: source-select bit set takes modulated level from software level register.
// RL13: controller calibrates externally for depths above 33 percent.
// RL14: external calibration writes normal level, measures, iterates level writes.
// RL15: controller writes best level to modulated register, restores normal level.
// RL16: two groups of four trim outputs; single-ended leaves second group open.
// RL17: trim switches of equal weight in both groups share one control bit.
// RL18: active trim bit closes switch to ground; inactive leaves capacitor floating.
// RL19: trim setting comes from automatic calibration or software control register.
// RL20: trim code is binary weighted, bit 0 least significant capacitor.
// RL21: signal completion after display update; ignore calibrate while running.
package amd_pkg;
	// register byte offsets
	localparam logic [7:0] A_DEPTH_CTRL = 8'h00;
	localparam logic [7:0] A_NORM_LVL   = 8'h04;
	localparam logic [7:0] A_MOD_LVL    = 8'h08;
	localparam logic [7:0] A_DEPTH_DISP = 8'h0c;
	localparam logic [7:0] A_ADC_OUT    = 8'h10;
	localparam logic [7:0] A_TRIM_CTRL  = 8'h14;
	localparam logic [7:0] A_CMD        = 8'h18;
	localparam logic [7:0] A_STATUS     = 8'h1c;
	// field positions
	localparam int DC_SEL_BIT  = 7;
	localparam int DC_CODE_LSB = 1;
	localparam int DEPTH_W     = 6;
	localparam int LVL_W       = 8;
	localparam int TRIM_W      = 4;
	localparam int TC_SEL_BIT  = 4;
	localparam int TC_DIFF_BIT = 5;
	localparam int CMD_CAL_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	// reset values
	localparam logic [7:0] NORM_LVL_RST   = 8'h00;
	localparam logic [7:0] MOD_LVL_RST    = 8'h00;
	localparam logic [5:0] DEPTH_CODE_RST = 6'h00;
	localparam logic [3:0] TRIM_CODE_RST  = 4'h0;
	// cycle counts and sequencing
	localparam logic [3:0] DIV_STEPS = 4'he;
	localparam int         DIV_NUM_W = 14;
	localparam logic [2:0] SAR_TOP   = 3'h7;
	localparam logic [7:0] SAR_FIRST = 8'h80;
	localparam logic [8:0] ERR_MAX   = 9'h100;

	typedef enum logic [2:0] {
		AMD_IDLE   = 3'b000,
		AMD_MEAS_N = 3'b001,
		AMD_DIV    = 3'b011,
		AMD_MEAS_T = 3'b010,
		AMD_FIN    = 3'b110
	} amd_state_e;
endpackage

// File: hw/amd_top.sv
// AM depth calibration, driver level select and register slave
`timescale 1ns/1ns
`default_nettype none
module amd_top
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        srst_in,
	// ahb-lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// modulator keying and measurement
	input  wire logic        mod_in,
	output logic             tx_en_out,
	output logic             adc_start_out,
	input  wire logic        adc_done_in,
	input  wire logic [7:0]  adc_data_in,
	output logic             cal_done_out,
	// driver segment enables, one per segment
	output logic      [7:0]  drive_out_a,
	output logic      [7:0]  drive_out_b,
	// antenna trim
	input  wire logic [3:0]  auto_trim_in,
	output logic      [3:0]  tune_sw_a,
	output logic      [3:0]  tune_sw_b
);
	typedef struct packed {
		amd_pkg::amd_state_e st;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
		logic        depth_sel;
		logic [5:0]  depth_code;
		logic [7:0]  norm_lvl;
		logic [7:0]  mod_lvl;
		logic [7:0]  disp;
		logic [7:0]  adc_reg;
		logic        trim_sel;
		logic [3:0]  trim_code;
		logic        diff_en;
		logic        done;
		logic        done_p;
		logic        adc_start;
		logic        div_start;
		logic        tx_en;
		logic [7:0]  drv;
		logic [7:0]  trial;
		logic [2:0]  bit_idx;
		logic [7:0]  target;
		logic [8:0]  best_err;
		logic [7:0]  best_lvl;
	} amd_top_s;

	amd_top_s r;
	amd_top_s next_r;
	logic        acc;
	logic        cal_go;
	logic        clr_done;
	logic [31:0] rd;
	logic [7:0]  err;
	logic [7:0]  kept;
	logic [7:0]  lvl;
	logic [7:0]  div_quo;
	logic        div_done;

	amd_div amd_div_inst
	(
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.start_in   (r.div_start),
		.num_in     ({r.adc_reg, 6'h00}),
		.den_in     ({1'b1, r.depth_code}),
		.quo_out    (div_quo),
		.done_out   (div_done)
	);

	amd_trim amd_trim_inst
	(
		.ref_clk_in    (ref_clk_in),
		.srst_in       (srst_in),
		.sw_sel_in     (r.trim_sel),
		.sw_code_in    (r.trim_code),
		.auto_code_in  (auto_trim_in),
		.diff_en_in    (r.diff_en),
		.tune_sw_a_out (tune_sw_a),
		.tune_sw_b_out (tune_sw_b)
	);

	assign acc = hsel_in && hready_in && htrans_in[1];

	// read mux, sampled in the address phase
	always_comb
	begin
		rd = 32'h0;
		if (haddr_in[7:0] == amd_pkg::A_DEPTH_CTRL)
			rd = {24'h0, r.depth_sel, r.depth_code, 1'b0};
		else if (haddr_in[7:0] == amd_pkg::A_NORM_LVL)
			rd = {24'h0, r.norm_lvl};
		else if (haddr_in[7:0] == amd_pkg::A_MOD_LVL)
			rd = {24'h0, r.mod_lvl};
		else if (haddr_in[7:0] == amd_pkg::A_DEPTH_DISP)
			rd = {24'h0, r.disp};
		else if (haddr_in[7:0] == amd_pkg::A_ADC_OUT)
			rd = {24'h0, r.adc_reg};
		else if (haddr_in[7:0] == amd_pkg::A_TRIM_CTRL)
			rd = {26'h0, r.diff_en, r.trim_sel, r.trim_code};
		else if (haddr_in[7:0] == amd_pkg::A_STATUS)
			rd = {30'h0, r.done, r.st != amd_pkg::AMD_IDLE};
	end

	always_comb
	begin
		next_r = r;
		cal_go = 1'b0;
		clr_done = 1'b0;
		err = 8'h00;
		kept = r.trial;
		next_r.adc_start = 1'b0;
		next_r.div_start = 1'b0;
		next_r.done_p = 1'b0;
		next_r.wr_pend = 1'b0;
		if (acc)
		begin
			next_r.wr_pend = hwrite_in;
			next_r.wr_addr = haddr_in[7:0];
			next_r.hrdata = hwrite_in ? 32'h0 : rd;
		end
		if (r.wr_pend)
		begin
			if (r.wr_addr == amd_pkg::A_DEPTH_CTRL)
			begin
				next_r.depth_sel = hwdata_in[amd_pkg::DC_SEL_BIT];
				next_r.depth_code = hwdata_in[amd_pkg::DC_CODE_LSB +: amd_pkg::DEPTH_W];
			end
			else if (r.wr_addr == amd_pkg::A_NORM_LVL)
				next_r.norm_lvl = hwdata_in[7:0];
			else if (r.wr_addr == amd_pkg::A_MOD_LVL)
				next_r.mod_lvl = hwdata_in[7:0];
			else if (r.wr_addr == amd_pkg::A_TRIM_CTRL)
			begin
				next_r.trim_code = hwdata_in[3:0];
				next_r.trim_sel = hwdata_in[amd_pkg::TC_SEL_BIT];
				next_r.diff_en = hwdata_in[amd_pkg::TC_DIFF_BIT];
			end
			else if (r.wr_addr == amd_pkg::A_CMD)
				cal_go = hwdata_in[amd_pkg::CMD_CAL_BIT];
			else if (r.wr_addr == amd_pkg::A_STATUS)
				clr_done = hwdata_in[amd_pkg::ST_DONE_BIT];
		end
		if (clr_done)
			next_r.done = 1'b0;

		case (r.st)
			amd_pkg::AMD_IDLE:
			begin
				// calibrate only accepted here, so repeats while running drop [RL21]
				if (cal_go)
				begin
					next_r.tx_en = 1'b1; // [RL6]
					next_r.trial = r.norm_lvl;
					next_r.adc_start = 1'b1;
					next_r.st = amd_pkg::AMD_MEAS_N;
				end
			end
			amd_pkg::AMD_MEAS_N:
			begin
				if (adc_done_in)
				begin
					next_r.adc_reg = adc_data_in; // [RL6]
					next_r.div_start = 1'b1; // [RL7]
					next_r.st = amd_pkg::AMD_DIV;
				end
			end
			amd_pkg::AMD_DIV:
			begin
				// divisor is 1.depth_code, so deeper codes give lower targets [RL1] [RL2]
				if (div_done)
				begin
					next_r.target = div_quo; // [RL7]
					next_r.trial = amd_pkg::SAR_FIRST;
					next_r.bit_idx = amd_pkg::SAR_TOP;
					next_r.best_err = amd_pkg::ERR_MAX;
					next_r.adc_start = 1'b1;
					next_r.st = amd_pkg::AMD_MEAS_T;
				end
			end
			amd_pkg::AMD_MEAS_T:
			begin
				if (adc_done_in)
				begin
					err = adc_data_in >= r.target ? 8'(adc_data_in - r.target) : 8'(r.target - adc_data_in);
					if ({1'b0, err} < r.best_err)
					begin
						next_r.best_err = {1'b0, err}; // [RL8]
						next_r.best_lvl = r.trial;
					end
					// field below target: this segment step went too far [RL8]
					if (adc_data_in < r.target)
						kept[r.bit_idx] = 1'b0;
					if (r.bit_idx == 3'h0)
					begin
						next_r.trial = kept;
						next_r.st = amd_pkg::AMD_FIN;
					end
					else
					begin
						next_r.bit_idx = r.bit_idx - 3'h1;
						next_r.trial = kept | (8'h01 << (r.bit_idx - 3'h1));
						next_r.adc_start = 1'b1;
					end
				end
			end
			amd_pkg::AMD_FIN:
			begin
				next_r.disp = r.best_lvl; // [RL9]
				next_r.done = 1'b1; // [RL21]
				next_r.done_p = 1'b1; // [RL21]
				next_r.tx_en = 1'b0;
				next_r.st = amd_pkg::AMD_IDLE;
			end
			default:
				next_r.st = amd_pkg::AMD_IDLE;
		endcase

		// level code counts segments switched off, higher means weaker drive
		if (r.st != amd_pkg::AMD_IDLE)
			lvl = r.trial;
		else if (!mod_in)
			lvl = r.norm_lvl; // [RL4]
		else if (r.depth_sel)
			lvl = r.mod_lvl; // [RL12]
		else
			lvl = r.disp; // [RL9]
		next_r.drv = ~lvl; // [RL3]
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			r <= '0;
			r.hready <= 1'b1;
			r.norm_lvl <= amd_pkg::NORM_LVL_RST;
			r.mod_lvl <= amd_pkg::MOD_LVL_RST;
			r.depth_code <= amd_pkg::DEPTH_CODE_RST;
			r.trim_code <= amd_pkg::TRIM_CODE_RST;
		end
		else
			r <= next_r;
	end

	assign hrdata_out = r.hrdata;
	assign hreadyout_out = r.hready;
	assign hresp_out = r.hresp;
	assign tx_en_out = r.tx_en;
	assign adc_start_out = r.adc_start;
	assign cal_done_out = r.done_p;
	assign drive_out_a = r.drv; // [RL3]
	assign drive_out_b = r.drv; // [RL3]

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	cal_start_a: assert property (r.st == amd_pkg::AMD_IDLE && cal_go |=> tx_en_out && adc_start_out) // [RL6]
		else $error("calibrate did not start transmitter and measurement");
	adc_store_a: assert property (r.st == amd_pkg::AMD_MEAS_N && adc_done_in // [RL6]
		|=> r.adc_reg == $past(adc_data_in) ##1 amd_div_inst.r.busy)
		else $error("unmodulated measurement not stored");
	target_load_a: assert property (r.st == amd_pkg::AMD_DIV && div_done // [RL7]
		|=> r.target == $past(div_quo) && adc_start_out)
		else $error("target level not taken from divider");
	sar_step_a: assert property (r.st == amd_pkg::AMD_MEAS_T && adc_done_in && r.bit_idx != 3'h0 // [RL8]
		|=> adc_start_out && r.bit_idx == $past(r.bit_idx) - 3'h1)
		else $error("approximation step skipped");
	level_run_a: assert property (r.st != amd_pkg::AMD_IDLE |=> drive_out_a == ~$past(r.trial)) // [RL8]
		else $error("drivers not at trial level during calibration");
	disp_write_a: assert property (r.st == amd_pkg::AMD_FIN // [RL9]
		|=> r.disp == $past(r.best_lvl) && cal_done_out ##1 !cal_done_out)
		else $error("display not written at end of calibration");
	done_flag_a: assert property (cal_done_out |-> r.done) // [RL21]
		else $error("completion pulse without done flag");
	busy_ignore_a: assert property (r.st != amd_pkg::AMD_IDLE && cal_go // [RL21]
		|=> r.st != amd_pkg::AMD_MEAS_N || $past(r.st) == amd_pkg::AMD_MEAS_N)
		else $error("calibrate restarted while running");
	sw_level_a: assert property (r.st == amd_pkg::AMD_IDLE && mod_in && r.depth_sel // [RL12]
		|=> drive_out_a == ~$past(r.mod_lvl))
		else $error("software modulated level not applied");
	norm_level_a: assert property (r.st == amd_pkg::AMD_IDLE && !mod_in // [RL4]
		|=> drive_out_b == ~$past(r.norm_lvl))
		else $error("unmodulated level not applied");
	cal_level_a: assert property (r.st == amd_pkg::AMD_IDLE && mod_in && !r.depth_sel // [RL9]
		|=> drive_out_a == ~$past(r.disp))
		else $error("calibrated level not applied");
endmodule
`default_nettype wire

// File: hw/amd_trim.sv
// antenna trim switch drive for both antenna sides
`timescale 1ns/1ns
`default_nettype none
module amd_trim
(
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       srst_in,
	// control
	input  wire logic       sw_sel_in,
	input  wire logic [3:0] sw_code_in,
	input  wire logic [3:0] auto_code_in,
	input  wire logic       diff_en_in,
	// switches, high closes to ground
	output logic      [3:0] tune_sw_a_out,
	output logic      [3:0] tune_sw_b_out
);
	typedef struct packed {
		logic [3:0] a;
		logic [3:0] b;
	} amd_trim_s;

	amd_trim_s r;
	amd_trim_s next_r;
	logic [3:0] code;

	always_comb
	begin
		next_r = r;
		code = sw_sel_in ? sw_code_in : auto_code_in; // [RL19]
		// bit i drives weight 2^i on side a, and on side b only when diff_en_in is set [RL20] [RL18]
		next_r.a = code;
		next_r.b = diff_en_in ? code : 4'h0; // [RL17] [RL16]
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign tune_sw_a_out = r.a;
	assign tune_sw_b_out = r.b;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	trim_pair_a: assert property (diff_en_in |=> tune_sw_b_out == tune_sw_a_out) // [RL17]
		else $error("trim groups differ in differential mode");
	trim_open_a: assert property (!diff_en_in |=> tune_sw_b_out == 4'h0) // [RL16]
		else $error("second trim group driven in single-ended mode");
	trim_src_a: assert property (sw_sel_in |=> tune_sw_a_out == $past(sw_code_in)) // [RL19]
		else $error("software trim code not applied");
endmodule
`default_nettype wire
